// File: hdl/twc_pkg.sv
/*
  twc_pkg: shared constants, field positions and state type of the
  three-wire serial channel. Assumes an 8-bit internal register bus with
  16-bit addresses and the channel logic running on one core clock.
*/
package twc_pkg;

  // ----------------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------------
  localparam logic [15:0] TWC_ADDR_MODE = 16'hFF68; // serial_channel_mode_ctl
  localparam logic [15:0] TWC_ADDR_AUTO = 16'hFF69; // auto_xfer_ctl
  localparam logic [15:0] TWC_ADDR_SBUF = 16'hFF6A; // shift_buffer
  localparam logic [15:0] TWC_ADDR_PTR = 16'hFF6B; // auto transfer pointer
  localparam logic [15:0] TWC_RAM_BASE = 16'hFAC0; // buffer ram first byte
  localparam logic [15:0] TWC_RAM_LAST = 16'hFADF; // buffer ram last byte

  // ----------------------------------------------------------------------
  // reset values and write masks
  // ----------------------------------------------------------------------
  localparam logic [7:0] TWC_MODE_RST = 8'h00;
  localparam logic [7:0] TWC_AUTO_RST = 8'h00;
  localparam logic [7:0] TWC_SBUF_RST = 8'h00;
  localparam logic [4:0] TWC_PTR_RST = 5'h00;
  localparam logic [7:0] TWC_MODE_WMASK = 8'hE3; // bits 4..2 fixed zero
  localparam logic [7:0] TWC_AUTO_WMASK = 8'hE7; // bits 4..3 read only

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int TWC_M_ON = 'h7;     // channel_on_bit
  localparam int TWC_M_DIR = 'h6;    // first bit select, 1 = lsb first
  localparam int TWC_M_ATE = 'h5;    // auto_xfer_select
  localparam int TWC_M_CLK_HI = 'h1; // clock_src_hi
  localparam int TWC_M_CLK_LO = 'h0; // clock_src_lo
  localparam int TWC_A_RE = 'h7;     // rx_on_bit
  localparam int TWC_A_ARLD = 'h6;   // repeat run
  localparam int TWC_A_ERCE = 'h5;   // error check enable
  localparam int TWC_A_ERR = 'h4;    // error seen, read only
  localparam int TWC_A_TRF = 'h3;    // run in progress, read only
  localparam int TWC_A_HANDSHAKE_OUT_ON = 'h2;   // handshake_out_on
  localparam int TWC_A_HANDSHAKE_IN_ON = 'h1;  // handshake_in_on
  localparam int TWC_A_BUSY0 = 'h0;  // busy polarity, 1 = active low

  // ----------------------------------------------------------------------
  // counts and sizes
  // ----------------------------------------------------------------------
  localparam logic [3:0] TWC_LAST_BIT = 4'h7; // index of eighth bit
  localparam int TWC_RAM_DEPTH = 'h20;
  localparam int TWC_RAM_AW = 'h5;

  typedef enum logic [2:0] {
    TWC_ST_IDLE  = 3'b000,
    TWC_ST_FETCH = 3'b001,
    TWC_ST_LOAD  = 3'b010,
    TWC_ST_SHIFT = 3'b011,
    TWC_ST_STORE = 3'b100,
    TWC_ST_HAND  = 3'b101
  } twc_state_type;

endpackage

// File: hdl/twc_buf_ram.sv
/*
  twc_buf_ram: 32 x 8 buffer memory for automatic multi-byte runs, one
  write port and one read port with registered read data.
  Assumes the caller arbitrates between software and the transfer engine.
*/
`timescale 1ns/100ps
module twc_buf_ram (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_we,
  input wire logic [twc_pkg::TWC_RAM_AW-1:0] i_waddr,
  input wire logic [7:0] i_wdata,
  input wire logic [twc_pkg::TWC_RAM_AW-1:0] i_raddr,
  output logic [7:0] o_rdata
);
  import twc_pkg::*;

  logic [7:0] mem_ff [TWC_RAM_DEPTH];

  // ----------------------------------------------------------------------
  // storage array, no reset
  // ----------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_we) begin
      mem_ff[i_waddr] <= i_wdata;
    end
  end

  // read data out of a register
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= mem_ff[i_raddr];
    end
  end

endmodule // twc_buf_ram

// File: hdl/twc_serial_channel.sv
/*
  twc_serial_channel: 8-bit three-wire synchronous serial channel with mode
  register, auto run control, shift buffer, run pointer and buffer ram.
  Assumes i_tmr2_out and i_prescale_tick are one-cycle ticks from timer
  logic on i_core_clk; pin inputs are asynchronous and synchronised here.
  // Contract
  // - reset clears the channel mode register to zero, channel off
  // - clock source bits pick external pin, timer two, or prescaler tap
  // - auto select bit picks plain mode or automatic multi-byte mode
  // - bit 6 of mode register picks msb first (0) or lsb first (1)
  // - channel off stops shifting and holds the bit counter cleared
  // - data moves in 8-bit units, one bit per serial clock period
  // - buffer shifts on falling serial clock; out latch drives out pin
  // - serial in pin is sampled into the buffer on rising clock
  // - after eighth bit the buffer halts and the done flag is set
  // - any software write to the shift buffer drives serial out low
  // - first bit order applied by reversing bits on write and read
  // - a buffer write starts a transfer only if on and clock idle
  // - switching the channel on after the write does not start one
  // - with receive off in auto mode the serial in pin is released
  // - auto mode sends and stores up to 32 ram bytes without software
  // - auto mode runs strobe and busy handshakes in hardware
  // - reset clears the auto transfer control register to zero
  // - a stopped channel keeps the buffer as a plain 8-bit register
*/
`timescale 1ns/100ps
module twc_serial_channel (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic [15:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  input wire logic i_tmr2_out,
  input wire logic i_prescale_tick,
  input wire logic i_sck_in,
  output logic o_sck_out,
  output logic o_sck_oe,
  input wire logic i_si_in,
  output logic o_si_claimed,
  output logic o_so_out,
  output logic o_so_oe,
  output logic o_strobe_out,
  output logic o_strobe_oe,
  input wire logic i_busy_in,
  input wire logic i_flag_clr,
  output logic o_xfer_done_flag
);
  import twc_pkg::*;

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  twc_state_type state_ff;
  twc_state_type nxt_state;
  logic [7:0] mode_ff;
  logic [7:0] auto_ff;
  logic [4:0] ptr_ff;
  logic [4:0] idx_ff;
  logic [7:0] sr_ff;
  logic [3:0] cnt_ff;
  logic sck_ff;
  logic sck_s1_ff, sck_s2_ff, sck_s3_ff;
  logic si_s1_ff, si_s2_ff;
  logic busy_s1_ff, busy_s2_ff;
  logic [1:0] rsel_ff;
  logic rd_pend_ff;
  logic [7:0] ram_rdata;
  logic [7:0] rev_wdata, rev_sr, rev_ram;
  logic ch_on, dir_lsb, auto_xfer_select, clk_int, rx_on;
  logic wr_mode, wr_auto, wr_sbuf, wr_ptr, hit_ram;
  logic shifting, start_ok, start, tick, fall, rise, last_rise;
  logic busy_hold, run_end, eng_we, cpu_we;

  assign ch_on = mode_ff[TWC_M_ON];
  assign dir_lsb = mode_ff[TWC_M_DIR];
  assign auto_xfer_select = mode_ff[TWC_M_ATE];
  assign clk_int = mode_ff[TWC_M_CLK_HI];
  assign rx_on = auto_ff[TWC_A_RE];

  // address decode of the internal register bus
  assign wr_mode = i_reg_wr && (i_reg_addr == TWC_ADDR_MODE);
  assign wr_auto = i_reg_wr && (i_reg_addr == TWC_ADDR_AUTO);
  assign wr_sbuf = i_reg_wr && (i_reg_addr == TWC_ADDR_SBUF);
  assign wr_ptr = i_reg_wr && (i_reg_addr == TWC_ADDR_PTR);
  assign hit_ram = (i_reg_addr >= TWC_RAM_BASE) && (i_reg_addr <= TWC_RAM_LAST);

  // bit reversal between bus and shift buffer
  generate
    for (genvar b = 0; b < 8; b++) begin : g_rev
      assign rev_wdata[b] = dir_lsb ? i_reg_wdata[7-b] : i_reg_wdata[b];
      assign rev_sr[b] = dir_lsb ? sr_ff[7-b] : sr_ff[b];
      assign rev_ram[b] = dir_lsb ? ram_rdata[7-b] : ram_rdata[b];
    end
  endgenerate

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sck_s1_ff <= 1'h1;
      sck_s2_ff <= 1'h1;
      sck_s3_ff <= 1'h1;
      si_s1_ff <= 1'h0;
      si_s2_ff <= 1'h0;
      busy_s1_ff <= 1'h0;
      busy_s2_ff <= 1'h0;
    end else begin
      sck_s1_ff <= i_sck_in;
      sck_s2_ff <= sck_s1_ff;
      sck_s3_ff <= sck_s2_ff;
      si_s1_ff <= i_si_in;
      si_s2_ff <= si_s1_ff;
      busy_s1_ff <= i_busy_in;
      busy_s2_ff <= busy_s1_ff;
    end
  end

  // ----------------------------------------------------------------------
  // serial clock edges
  // ----------------------------------------------------------------------
  assign shifting = (state_ff == TWC_ST_SHIFT);
  assign tick = mode_ff[TWC_M_CLK_LO] ? i_prescale_tick : i_tmr2_out;
  assign fall = shifting && (clk_int ? (tick && sck_ff) : (sck_s3_ff && !sck_s2_ff));
  assign rise = shifting && (clk_int ? (tick && !sck_ff) : (!sck_s3_ff && sck_s2_ff));
  assign last_rise = rise && (cnt_ff == TWC_LAST_BIT);
  // start only if internal clock stopped or external pin high
  assign start_ok = clk_int ? !shifting : sck_s2_ff;
  assign start = wr_sbuf && ch_on && (state_ff == TWC_ST_IDLE) && start_ok;
  assign busy_hold = auto_ff[TWC_A_HANDSHAKE_IN_ON] && (busy_s2_ff ^ auto_ff[TWC_A_BUSY0]);
  assign run_end = (idx_ff == 5'h00) && !auto_ff[TWC_A_ARLD];

  // ----------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_ff <= TWC_MODE_RST;
    end else if (wr_mode) begin
      mode_ff <= i_reg_wdata & TWC_MODE_WMASK;
    end
  end

  // auto control, run flag set by start and cleared at run end
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      auto_ff <= TWC_AUTO_RST;
      ptr_ff <= TWC_PTR_RST;
    end else begin
      if (wr_auto) begin
        auto_ff[7:5] <= i_reg_wdata[7:5];
        auto_ff[2:0] <= i_reg_wdata[2:0];
      end
      if (wr_ptr) begin
        ptr_ff <= i_reg_wdata[4:0];
      end
      if (start && auto_xfer_select) begin
        auto_ff[TWC_A_TRF] <= 1'h1;
        auto_ff[TWC_A_ERR] <= 1'h0;
      end else if (!ch_on || (state_ff == TWC_ST_HAND && !busy_hold && run_end)) begin
        auto_ff[TWC_A_TRF] <= 1'h0;
      end
      // busy still asserted when a byte ends counts as an error
      if (state_ff == TWC_ST_STORE && auto_ff[TWC_A_ERCE] && busy_hold) begin
        auto_ff[TWC_A_ERR] <= 1'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // transfer state machine
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      TWC_ST_IDLE: begin
        if (start) begin
          nxt_state = auto_xfer_select ? TWC_ST_FETCH : TWC_ST_SHIFT;
        end
      end
      TWC_ST_FETCH: nxt_state = TWC_ST_LOAD;
      TWC_ST_LOAD: nxt_state = TWC_ST_SHIFT;
      TWC_ST_SHIFT: begin
        if (last_rise) begin
          nxt_state = auto_xfer_select ? TWC_ST_STORE : TWC_ST_IDLE;
        end
      end
      TWC_ST_STORE: nxt_state = TWC_ST_HAND;
      TWC_ST_HAND: begin
        if (!busy_hold) begin
          nxt_state = run_end ? TWC_ST_IDLE : TWC_ST_FETCH;
        end
      end
      default: nxt_state = TWC_ST_IDLE;
    endcase
    if (!ch_on) begin
      nxt_state = TWC_ST_IDLE;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_ff <= TWC_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // byte index, counts down from the pointer to zero
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      idx_ff <= 5'h00;
    end else if (start) begin
      idx_ff <= ptr_ff;
    end else if (state_ff == TWC_ST_HAND && !busy_hold) begin
      idx_ff <= (idx_ff == 5'h00) ? ptr_ff : idx_ff - 5'h01;
    end
  end

  // ----------------------------------------------------------------------
  // shift buffer, bit counter and serial clock
  // ----------------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sr_ff <= TWC_SBUF_RST;
    end else if (wr_sbuf && !shifting) begin
      sr_ff <= rev_wdata;
    end else if (state_ff == TWC_ST_LOAD) begin
      sr_ff <= rev_ram;
    end else if (fall) begin
      sr_ff <= {sr_ff[6:0], 1'h0};
    end else if (rise) begin
      sr_ff[0] <= si_s2_ff;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_ff <= 4'h0;
    end else if (!ch_on || !shifting) begin
      cnt_ff <= 4'h0;
    end else if (rise) begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end

  // internal serial clock idles high and toggles per tick while shifting
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sck_ff <= 1'h1;
    end else if (!shifting || !clk_int) begin
      sck_ff <= 1'h1;
    end else if (tick) begin
      sck_ff <= !sck_ff;
    end
  end

  // ----------------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_so_out <= 1'h0;
      o_so_oe <= 1'h0;
      o_sck_out <= 1'h1;
      o_sck_oe <= 1'h0;
      o_si_claimed <= 1'h0;
      o_strobe_out <= 1'h0;
      o_strobe_oe <= 1'h0;
    end else begin
      if (wr_sbuf) begin
        o_so_out <= 1'h0;
      end else if (fall) begin
        o_so_out <= sr_ff[7];
      end
      o_so_oe <= ch_on;
      o_sck_out <= sck_ff;
      o_sck_oe <= ch_on && clk_int;
      o_si_claimed <= ch_on && !(auto_xfer_select && !rx_on);
      o_strobe_out <= (state_ff == TWC_ST_STORE) && auto_ff[TWC_A_HANDSHAKE_OUT_ON];
      o_strobe_oe <= ch_on && auto_xfer_select && auto_ff[TWC_A_HANDSHAKE_OUT_ON];
    end
  end

  // done flag, a new end wins over a clear in the same cycle
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_xfer_done_flag <= 1'h0;
    end else if (last_rise) begin
      o_xfer_done_flag <= 1'h1;
    end else if (i_flag_clr) begin
      o_xfer_done_flag <= 1'h0;
    end
  end

  // ----------------------------------------------------------------------
  // buffer ram and read path
  // ----------------------------------------------------------------------
  assign eng_we = (state_ff == TWC_ST_STORE) && rx_on;
  assign cpu_we = i_reg_wr && hit_ram && !eng_we;

  twc_buf_ram u_buf_ram (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_we(eng_we || cpu_we),
    .i_waddr(eng_we ? idx_ff : i_reg_addr[4:0]),
    .i_wdata(eng_we ? rev_sr : i_reg_wdata),
    .i_raddr((state_ff == TWC_ST_FETCH) ? idx_ff : i_reg_addr[4:0]),
    .o_rdata(ram_rdata)
  );

  // read answered two edges after the request
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rd_pend_ff <= 1'h0;
      rsel_ff <= 2'h0;
      o_reg_rvalid <= 1'h0;
      o_reg_rdata <= 8'h00;
    end else begin
      rd_pend_ff <= i_reg_rd;
      if (i_reg_rd) begin
        rsel_ff <= (i_reg_addr == TWC_ADDR_MODE) ? 2'h1 :
                   (i_reg_addr == TWC_ADDR_SBUF) ? 2'h2 :
                   hit_ram ? 2'h3 : 2'h0;
        if (i_reg_addr == TWC_ADDR_AUTO) begin
          rsel_ff <= 2'h0;
        end
      end
      o_reg_rvalid <= rd_pend_ff;
      if (rd_pend_ff) begin
        case (rsel_ff)
          2'h1: o_reg_rdata <= mode_ff;
          2'h2: o_reg_rdata <= rev_sr;
          2'h3: o_reg_rdata <= ram_rdata;
          default: o_reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);

  // falling serial clock edges seen in the current byte
  logic [3:0] falls_seen_ff;
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      falls_seen_ff <= 4'h0;
    end else if (!shifting) begin
      falls_seen_ff <= 4'h0;
    end else if (fall) begin
      falls_seen_ff <= falls_seen_ff + 4'h1;
    end
  end

  sequence s_plain_start;
    wr_sbuf && ch_on && !auto_xfer_select && state_ff == TWC_ST_IDLE && start_ok;
  endsequence
  sequence s_shift_run;
    state_ff == TWC_ST_SHIFT && cnt_ff == 4'h0;
  endsequence

  a_mode_rsvd_zero: assert property (mode_ff[4:2] == 3'h0)
    else $error("reserved mode bits not zero");
  a_off_clears_cnt: assert property (!ch_on |=> cnt_ff == 4'h0 && !shifting)
    else $error("counter or shifting active with channel off");
  a_write_so_low: assert property (wr_sbuf |=> !o_so_out)
    else $error("serial out not low after buffer write");
  a_done_sets_flag: assert property (last_rise |=> o_xfer_done_flag && !shifting)
    else $error("done flag not set or shifting after eighth bit");
  a_off_no_start: assert property (wr_sbuf && !ch_on |=> state_ff == TWC_ST_IDLE)
    else $error("transfer started with channel off");
  a_plain_start: assert property (s_plain_start |=> s_shift_run)
    else $error("plain transfer did not start");
  a_sck_drive: assert property (ch_on && clk_int |=> o_sck_oe)
    else $error("clock pin not driven with internal clock");
  a_sck_release: assert property (!(ch_on && clk_int) |=> !o_sck_oe)
    else $error("clock pin driven without internal clock");
  a_fall_shift: assert property (fall |=> o_so_out == $past(sr_ff[7]))
    else $error("serial out does not hold shifted bit");
  a_rise_sample: assert property (rise && !fall |=> sr_ff[0] == $past(si_s2_ff))
    else $error("serial in not sampled on rising edge");
  a_eight_bits: assert property (last_rise |-> falls_seen_ff == 4'h8)
    else $error("byte ended after wrong bit count");

endmodule // twc_serial_channel

// File: dv/twc_peer_model.sv
/*
  twc_peer_model: far-side serial peripheral, shifts msb first on the wire.
  Assumes a resolved serial clock wire and a load pulse before each frame.
*/
`timescale 1ns/100ps
module twc_peer_model (
  input wire logic i_core_clk,
  input wire logic i_load,
  input wire logic [7:0] i_tx,
  input wire logic i_sck,
  input wire logic i_so,
  output logic o_si,
  output logic [7:0] o_rx,
  output logic [3:0] o_cnt
);
  logic sck_d = 1'b1;
  logic tg = 1'b0;
  logic [3:0] ocnt = 4'h0;
  logic [3:0] hc = 4'h0;
  logic [7:0] tx_ff = 8'h00;
  logic [3:0] oidx;
  // ----------------------------------------------------------------------
  // frame tracking
  // ----------------------------------------------------------------------
  // capture on rising clock, present next bit after falling clock
  always @(posedge i_core_clk) begin
    sck_d <= i_sck;
    tg <= ~tg;
    hc <= (o_cnt == 4'h8 && hc != 4'hF) ? hc + 4'h1 : hc;
    if (i_load) begin
      tx_ff <= i_tx;
      o_cnt <= 4'h0;
      ocnt <= 4'h0;
      hc <= 4'h0;
    end else if (i_sck && !sck_d) begin
      if (!o_cnt[3]) o_rx <= {o_rx[6:0], i_so};
      o_cnt <= o_cnt + 4'h1;
    end else if (!i_sck && sck_d) begin
      ocnt <= o_cnt;
    end
  end
  // next bit shows at once on a falling clock, not a core cycle later
  assign oidx = (!i_sck && sck_d) ? o_cnt : ocnt;
  // line keeps changing once the frame's hold time has run out
  assign o_si = (hc == 4'hF || oidx[3]) ? tg : tx_ff[3'h7 - oidx[2:0]];
endmodule // twc_peer_model

// File: dv/three_wire_serial_channel_tb_top.sv
/*
  three_wire_serial_channel_tb_top: self-checking bench, model of wire and
  buffer compared with the channel. Assumes twc_pkg and the peer model.
*/
`timescale 1ns/100ps
module three_wire_serial_channel_tb_top;
  import twc_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic [7:0] ptx = 8'h00;
  logic wr = 1'b0, rd = 1'b0, tmr2 = 1'b0, pre = 1'b0, fclr = 1'b0, pld = 1'b1;
  logic ten = 1'b0, psel = 1'b0, ext_en = 1'b0, ext_sck = 1'b1;
  logic [7:0] rdata, prx;
  logic [3:0] pcnt;
  logic [2:0] tc = 3'h0;
  logic rvalid, sck_o, sck_oe, si, claimed, so, so_oe, flag, sck_w;
  logic stb_o, stb_oe, stb_seen = 1'b0;
  int err_count = 0;
  int num_checks = 0;
  // ----------------------------------------------------------------------
  // clocks and wires
  // ----------------------------------------------------------------------
  // free-running core clock
  always #2 i_core_clk = ~i_core_clk;
  // resolved clock wire, driven by the peer side only for external clock
  assign sck_w = sck_oe ? sck_o : ext_sck;
  // tick sources; external clock idles high outside frames
  always @(posedge i_core_clk) begin
    tc <= tc + 3'h1;
    tmr2 <= ten && !psel && tc[1:0] == 2'h0;
    pre <= ten && psel && tc[1:0] == 2'h0;
    ext_sck <= !ext_en || (tc == 3'h0 ? ~ext_sck : ext_sck);
    stb_seen <= stb_seen || stb_o;
  end
  twc_serial_channel u_twc_serial_channel (
    .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_reg_addr(addr),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .i_tmr2_out(tmr2), .i_prescale_tick(pre),
    .i_sck_in(sck_w), .o_sck_out(sck_o), .o_sck_oe(sck_oe), .i_si_in(si),
    .o_si_claimed(claimed), .o_so_out(so), .o_so_oe(so_oe), .o_strobe_out(stb_o),
    .o_strobe_oe(stb_oe), .i_busy_in(1'b0), .i_flag_clr(fclr), .o_xfer_done_flag(flag)
  );
  twc_peer_model u_twc_peer_model (
    .i_core_clk(i_core_clk), .i_load(pld), .i_tx(ptx), .i_sck(sck_w),
    .i_so(so), .o_si(si), .o_rx(prx), .o_cnt(pcnt)
  );
  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic fail_out(input string m);
    err_count++;
    $display("FAIL t=%0t %s", $time, m);
    give_verdict;
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("FAIL t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rw(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_core_clk);
    wr <= 1'b0;
  endtask
  task automatic chkreg(input logic [15:0] a, input logic [7:0] e);
    int n;
    @(posedge i_core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_core_clk);
    rd <= 1'b0;
    for (n = 0; n < 8 && rvalid !== 1'b1; n++) @(posedge i_core_clk);
    if (n == 8) fail_out("no read answer");
    chk8(rdata, e);
  endtask
  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev[i] = v[7 - i];
  endfunction
  // one whole byte frame with peer, then buffer and flag checks
  task automatic xfer(input logic [7:0] m, input logic [7:0] d);
    int n;
    rw(TWC_ADDR_MODE, m);
    pld <= 1'b1;
    ptx <= 8'($urandom);
    @(posedge i_core_clk);
    pld <= 1'b0;
    rw(TWC_ADDR_SBUF, d);
    @(posedge i_core_clk);
    #1;
    chk8({7'h00, so}, 8'h00);
    chk8({7'h00, sck_oe}, {7'h00, m[1]});
    @(posedge i_core_clk);
    ten <= m[1];
    psel <= m[0];
    ext_en <= !m[1];
    for (n = 0; n < 400 && flag !== 1'b1; n++) @(posedge i_core_clk);
    if (n == 400) fail_out("no done flag");
    ext_en <= 1'b0;
    repeat (40) @(posedge i_core_clk);
    ten <= 1'b0;
    chk8(prx, m[6] ? rev(d) : d);
    chk8({4'h0, pcnt}, 8'h08);
    chk8({7'h00, flag}, 8'h01);
    chkreg(TWC_ADDR_SBUF, m[6] ? rev(ptx) : ptx);
    fclr <= 1'b1;
    @(posedge i_core_clk);
    fclr <= 1'b0;
    @(posedge i_core_clk);
    #1;
    chk8({7'h00, flag}, 8'h00);
  endtask
  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    logic [7:0] d;
    logic [7:0] modes [4];
    modes = '{8'h82, 8'hC3, 8'h80, 8'hC1};
    d = 8'($urandom(32'hCD290F03));
    repeat (6) @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    pld <= 1'b0;
    chkreg(TWC_ADDR_MODE, 8'h00);
    chkreg(TWC_ADDR_AUTO, 8'h00);
    chk8({5'h00, sck_oe, so_oe, claimed}, 8'h00);
    rw(TWC_ADDR_MODE, 8'h1E);
    chkreg(TWC_ADDR_MODE, 8'h02);
    d = 8'($urandom);
    rw(TWC_ADDR_SBUF, d);
    rw(TWC_ADDR_MODE, 8'h82);
    ten <= 1'b1;
    repeat (60) @(posedge i_core_clk);
    ten <= 1'b0;
    chkreg(TWC_ADDR_SBUF, d);
    chk8({7'h00, flag}, 8'h00);
    chk8({7'h00, claimed}, 8'h01);
    for (int k = 0; k < 4; k++) xfer(modes[k], 8'($urandom));
    // one-byte automatic run: send ram byte zero, store the answer there
    d = 8'($urandom);
    rw(TWC_RAM_BASE, d);
    rw(TWC_ADDR_AUTO, 8'h84);
    chk8({7'h00, stb_seen}, 8'h00);
    xfer(8'hA2, d);
    chkreg(TWC_RAM_BASE, ptx);
    chk8({6'h00, stb_seen, stb_oe}, 8'h03);
    rw(TWC_ADDR_MODE, 8'hA2);
    rw(TWC_ADDR_AUTO, 8'h00);
    @(posedge i_core_clk);
    #1;
    chk8({7'h00, claimed}, 8'h00);
    rw(TWC_ADDR_MODE, 8'h02);
    repeat (2) @(posedge i_core_clk);
    #1;
    chk8({6'h00, sck_oe, so_oe}, 8'h00);
    give_verdict;
  end
endmodule // three_wire_serial_channel_tb_top
